// [hdl/dcsp_pkg.sv]
/*
  Constants, register map and types for the dual channel serial port.
  Assumes a single mclk domain at 250 MHz and an APB register slave.
*/
// How it works
// RULE1 - Internal clock: halve, then 4-bit up-count; code counts first, then halves
// RULE2 - Transmit MSB first on rising clock
// RULE3 - Receive MSB first on falling clock
// RULE4 - Frame sync high brackets every transfer
// RULE5 - Frame done gives one-cycle low pulse
// RULE6 - Disabled port drives and starts nothing
// RULE7 - Clock and sync each internal or external
// RULE8 - External timing paces the shifting
// RULE9 - Transmit and receive in same frame
// RULE10 - Register pair per channel, own sync
// RULE11 - 8/16-bit uses first register; stereo all; code sends 8/16-bit from the second (load) register, receives into the first
// RULE12 - Two control words split the controls
// RULE13 - Optional mu-law compression in 8-bit transmit
// RULE14 - 16-bit linear passes data unchanged
// RULE15 - Stereo frame is 64 bits, four words
// RULE16 - Written load word goes out next frame
// RULE17 - Control pair loaded by two writes
// RULE18 - Internal sync high exactly frame length
package dcsp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int FRAME_W = 64;

  // Data words: 0 ch0 hold, 1 ch0 load, 2 ch1 hold, 3 ch1 load
  localparam logic [ADDR_W-1:0] OFS_CH0_HOLD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CH0_LOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CH1_HOLD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CH1_LOAD = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WCC = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] DATA_OFS [4] = '{OFS_CH0_HOLD, OFS_CH0_LOAD,
                                                 OFS_CH1_HOLD, OFS_CH1_LOAD};

  // serial_port_control fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_FS_INT = 2;
  localparam int CTL_CH0_EN = 3;
  // waitstate_clock_control fields
  localparam int WCC_PS_LSB = 0;
  localparam int WCC_SCLK_INT = 4;
  localparam int WCC_CH1_EN = 5;
  localparam int WCC_WAIT_LSB = 8;

  localparam logic [WORD_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [WORD_W-1:0] WCC_RST = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  localparam logic [1:0] MODE_PCM8 = 2'h0;
  localparam logic [1:0] MODE_ULAW8 = 2'h1;
  localparam logic [1:0] MODE_LIN16 = 2'h2;
  localparam logic [1:0] MODE_STEREO = 2'h3;

  localparam logic [6:0] LEN_8 = 7'h08;
  localparam logic [6:0] LEN_16 = 7'h10;
  localparam logic [6:0] LEN_64 = 7'h40;

  localparam int IRQ_CH0 = 0;
  localparam int IRQ_CH1 = 1;

  localparam logic [15:0] ULAW_CLIP = 16'h7F7B;
  localparam logic [15:0] ULAW_BIAS = 16'h0084;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } dcsp_state_e;

  function automatic logic [6:0] frame_len(input logic [1:0] mode);
    case (mode)
      MODE_LIN16: frame_len = LEN_16;
      MODE_STEREO: frame_len = LEN_64;
      default: frame_len = LEN_8;
    endcase
  endfunction
endpackage

// [hdl/dcsp_prescaler.sv]
/*
  Serial clock generator: mclk divided by a 4-bit value, then halved.
  Assumes run is synchronous to mclk; a prescale of zero divides by 16.
*/
`timescale 1ns/10ps
module dcsp_prescaler (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire logic [3:0] ps,
  output logic sclk_lvl,
  output logic sclk_rise,
  output logic sclk_fall
);
  logic [3:0] cnt_r;
  logic tick;

  // RULE1 up-counter prescaler
  assign tick = run && (cnt_r == 4'(ps - 4'h1));

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_r <= 4'h0;
    end else if (!run || tick) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= 4'(cnt_r + 4'h1);
    end
  end

  // RULE1 divide by two
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_lvl <= 1'b0;
    end else if (!run) begin
      sclk_lvl <= 1'b0;
    end else if (tick) begin
      sclk_lvl <= ~sclk_lvl;
    end
  end

  assign sclk_rise = tick && !sclk_lvl;
  assign sclk_fall = tick && sclk_lvl;
endmodule

// [hdl/dcsp_ulaw.sv]
/*
  Linear 16-bit to 8-bit mu-law compressor, purely combinational.
  Assumes two's complement input; expansion is left to software.
*/
`timescale 1ns/10ps
module dcsp_ulaw (
  input wire logic [15:0] lin,
  output logic [7:0] code
);
  import dcsp_pkg::*;
  logic sign;
  logic [15:0] mag;
  logic [15:0] biased;
  logic [2:0] expo;
  logic [15:0] shifted;

  // RULE13 mu-law compression
  always_comb begin
    sign = lin[15];
    mag = sign ? 16'(~lin + 16'h0001) : lin;
    if (mag > ULAW_CLIP) begin
      mag = ULAW_CLIP;
    end
    biased = 16'(mag + ULAW_BIAS);
    expo = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (biased[7 + i]) begin
        expo = 3'(i);
      end
    end
    // Four bits wide so segment 5 and up do not wrap the shift
    shifted = biased >> ({1'b0, expo} + 4'h3);
    code = ~{sign, expo, shifted[3:0]};
  end
endmodule

// [hdl/dcsp_serial_port.sv]
/*
  Dual channel serial port with APB registers, frame engine and interrupt.
  Assumes all pins are synchronous to mclk; external serial clock and
  frame syncs are sampled and edge-detected, so they must run well below
  mclk/4.
*/
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module dcsp_serial_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [dcsp_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcsp_pkg::DATA_W-1:0] pwdata,
  output logic [dcsp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n,
  input wire logic frame_sync_ch0_in,
  output logic frame_sync_ch0_out,
  output logic frame_sync_ch0_oe_n,
  input wire logic frame_sync_ch1_in,
  output logic frame_sync_ch1_out,
  output logic frame_sync_ch1_oe_n,
  output logic txd,
  output logic txd_oe_n,
  input wire logic rxd,
  output logic irq,
  output logic serial_port_irq_n
);
  import dcsp_pkg::*;

  logic [WORD_W-1:0] ctl_r;
  logic [WORD_W-1:0] wcc_r;
  logic [WORD_W-1:0] tx_word_r [4];
  logic [WORD_W-1:0] rx_word_r [4];
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  dcsp_state_e state_r;
  logic ch_r;
  logic next_ch_r;
  logic [6:0] bit_cnt_r;
  logic [FRAME_W-1:0] tx_sh_r;
  logic [FRAME_W-1:0] rx_sh_r;
  logic [1:0] fs_out_r;
  logic txd_r;
  logic irq_pulse_r;
  logic sclk_in_r, sclk_prev_r;
  logic fs0_in_r, fs0_prev_r, fs1_in_r, fs1_prev_r;

  logic wr_en, rd_setup, addr_ok;
  logic [1:0] mode;
  logic fs_int, sclk_int, ch0_en, ch1_en, port_en, stereo;
  logic [6:0] len;
  logic p_lvl, p_rise, p_fall;
  logic sck_rise, sck_fall;
  logic start, start_ch;
  logic ext_fs_cur;
  logic last_bit;
  logic [FRAME_W-1:0] tx_frame;
  logic [7:0] ulaw_code;
  logic [WORD_W-1:0] lin_word;
  logic [DATA_W-1:0] rd_val;

  // APB decode
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  // Answer always in the first access cycle
  assign pready = 1'b1;

  always_comb begin
    addr_ok = 1'b1;
    rd_val = '0;
    case (paddr)
      OFS_CH0_HOLD: rd_val = {16'h0000, rx_word_r[0]};
      OFS_CH0_LOAD: rd_val = {16'h0000, rx_word_r[1]};
      OFS_CH1_HOLD: rd_val = {16'h0000, rx_word_r[2]};
      OFS_CH1_LOAD: rd_val = {16'h0000, rx_word_r[3]};
      OFS_CTRL: rd_val = {16'h0000, ctl_r};
      OFS_WCC: rd_val = {16'h0000, wcc_r};
      OFS_IRQ_STAT: rd_val = {30'h00000000, irq_stat_r};
      OFS_IRQ_MASK: rd_val = {30'h00000000, irq_mask_r};
      OFS_STATUS: rd_val = {19'h00000, bit_cnt_r, fs_out_r, ch_r, state_r};
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data sampled in setup so it comes from flip-flops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? '0 : rd_val;
      pslverr <= !addr_ok;
    end
  end

  // RULE12 control word split
  // RULE17 pair of control writes
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctl_r <= CTRL_RST;
      wcc_r <= WCC_RST;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        ctl_r <= pwdata[WORD_W-1:0];
      end
      if (paddr == OFS_WCC) begin
        wcc_r <= pwdata[WORD_W-1:0];
      end
    end
  end

  assign mode = ctl_r[CTL_MODE_LSB +: 2];
  assign fs_int = ctl_r[CTL_FS_INT];
  assign ch0_en = ctl_r[CTL_CH0_EN];
  assign sclk_int = wcc_r[WCC_SCLK_INT];
  assign ch1_en = wcc_r[WCC_CH1_EN];
  assign stereo = (mode == MODE_STEREO);
  assign port_en = ch0_en || (ch1_en && !stereo);
  assign len = frame_len(mode);

  // RULE16 load words written by software
  // RULE10 one register pair per channel
  generate
    for (genvar g = 0; g < 4; g++) begin : g_words
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          tx_word_r[g] <= WORD_RST;
        end else if (wr_en && paddr == DATA_OFS[g]) begin
          tx_word_r[g] <= pwdata[WORD_W-1:0];
        end
      end

      // RULE11 received word placement
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          rx_word_r[g] <= WORD_RST;
        end else if (state_r == ST_DONE) begin
          if (stereo) begin
            rx_word_r[g] <= rx_sh_r[FRAME_W-1-WORD_W*g -: WORD_W];
          end else if (g == 2 * int'(ch_r)) begin
            rx_word_r[g] <= (mode == MODE_LIN16) ? rx_sh_r[WORD_W-1:0]
                                                 : {8'h00, rx_sh_r[7:0]};
          end
        end
      end
    end
  endgenerate

  // Pin samplers; inputs are already synchronous
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_in_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      fs0_in_r <= 1'b0;
      fs0_prev_r <= 1'b0;
      fs1_in_r <= 1'b0;
      fs1_prev_r <= 1'b0;
    end else begin
      sclk_in_r <= sclk_in;
      sclk_prev_r <= sclk_in_r;
      fs0_in_r <= frame_sync_ch0_in;
      fs0_prev_r <= fs0_in_r;
      fs1_in_r <= frame_sync_ch1_in;
      fs1_prev_r <= fs1_in_r;
    end
  end

  dcsp_prescaler u_presc (
    .mclk(mclk),
    .reset(reset),
    .run(port_en && sclk_int),
    .ps(wcc_r[WCC_PS_LSB +: 4]),
    .sclk_lvl(p_lvl),
    .sclk_rise(p_rise),
    .sclk_fall(p_fall)
  );

  // RULE7 clock source select
  // RULE8 external clock paces shifting
  assign sck_rise = port_en && (sclk_int ? p_rise : (sclk_in_r && !sclk_prev_r));
  assign sck_fall = port_en && (sclk_int ? p_fall : (!sclk_in_r && sclk_prev_r));

  // Transmit frame assembly
  assign lin_word = tx_word_r[{ch_sel(start_ch), 1'b1}];

  function automatic logic ch_sel(input logic c);
    ch_sel = c;
  endfunction

  dcsp_ulaw u_ulaw (
    .lin(lin_word),
    .code(ulaw_code)
  );

  always_comb begin
    case (mode)
      // RULE13 compressed byte
      MODE_ULAW8: tx_frame = {ulaw_code, 56'h0};
      // RULE14 linear, uncompressed
      MODE_LIN16: tx_frame = {lin_word, 48'h0};
      // RULE15 64-bit stereo frame
      MODE_STEREO: tx_frame = {tx_word_r[0], tx_word_r[1], tx_word_r[2], tx_word_r[3]};
      default: tx_frame = {lin_word[7:0], 56'h0};
    endcase
  end

  // Frame start: internal sync alternates channels, external waits for edge
  always_comb begin
    start = 1'b0;
    start_ch = 1'b0;
    if (fs_int) begin
      start_ch = !stereo && ch1_en && (next_ch_r || !ch0_en);
      start = sck_fall;
    end else if (fs0_in_r && !fs0_prev_r && ch0_en) begin
      start = 1'b1;
    end else if (fs1_in_r && !fs1_prev_r && ch1_en && !stereo) begin
      start = 1'b1;
      start_ch = 1'b1;
    end
  end

  assign ext_fs_cur = ch_r ? fs1_in_r : fs0_in_r;
  assign last_bit = (bit_cnt_r == 7'(len - 7'h01));

  // RULE6 nothing starts while disabled
  // RULE4 sync encloses the data
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      ch_r <= 1'b0;
      bit_cnt_r <= 7'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          bit_cnt_r <= 7'h00;
          if (port_en && start) begin
            state_r <= ST_SHIFT;
            ch_r <= start_ch;
          end
        end
        ST_SHIFT: begin
          if (!port_en || (!fs_int && !ext_fs_cur)) begin
            state_r <= ST_IDLE;
          end else if (sck_fall) begin
            bit_cnt_r <= 7'(bit_cnt_r + 7'h01);
            if (last_bit) begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      next_ch_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      next_ch_r <= !ch_r;
    end
  end

  // RULE18 internal sync lasts frame length
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fs_out_r <= 2'b00;
    end else if (state_r == ST_IDLE && port_en && start && fs_int) begin
      fs_out_r <= start_ch ? 2'b10 : 2'b01;
    end else if (state_r != ST_SHIFT || !port_en || (sck_fall && last_bit)) begin
      fs_out_r <= 2'b00;
    end
  end

  // RULE2 MSB first on rising edge
  // RULE9 full duplex shift registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_sh_r <= '0;
      txd_r <= 1'b0;
    end else if (state_r == ST_IDLE && port_en && start) begin
      tx_sh_r <= tx_frame;
      txd_r <= 1'b0;
    end else if (state_r == ST_SHIFT && sck_rise) begin
      txd_r <= tx_sh_r[FRAME_W-1];
      tx_sh_r <= {tx_sh_r[FRAME_W-2:0], 1'b0};
    end else if (state_r != ST_SHIFT) begin
      txd_r <= 1'b0;
    end
  end

  // RULE3 sample on falling edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_sh_r <= '0;
    end else if (state_r == ST_SHIFT && sck_fall) begin
      rx_sh_r <= {rx_sh_r[FRAME_W-2:0], rxd};
    end
  end

  // RULE5 one-cycle low completion pulse
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_pulse_r <= 1'b0;
    end else begin
      irq_pulse_r <= (state_r == ST_DONE);
    end
  end
  assign serial_port_irq_n = !irq_pulse_r;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
    end else begin
      if (wr_en && paddr == OFS_IRQ_MASK) begin
        irq_mask_r <= pwdata[1:0];
      end
      irq_stat_r <= (irq_stat_r & ~((wr_en && paddr == OFS_IRQ_STAT) ? pwdata[1:0] : 2'b00))
                    | ((state_r == ST_DONE) ? (ch_r ? 2'b10 : 2'b01) : 2'b00);
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // RULE6 no drive while disabled
  assign sclk_out = p_lvl;
  assign sclk_oe_n = !(port_en && sclk_int);
  assign frame_sync_ch0_out = fs_out_r[0];
  assign frame_sync_ch0_oe_n = !(port_en && fs_int && ch0_en);
  assign frame_sync_ch1_out = fs_out_r[1];
  assign frame_sync_ch1_oe_n = !(port_en && fs_int && ch1_en && !stereo);
  assign txd = txd_r;
  assign txd_oe_n = !port_en;
endmodule

// [test/dcsp_serial_port_assertions.sv]
/*
  Checker on the serial port top: APB answer, drive enables, irq pulse.
  Assumes binding from tb_top and the single mclk domain.
*/
`timescale 1ns/10ps
module dcsp_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [dcsp_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk_oe_n,
  input wire logic frame_sync_ch0_out,
  input wire logic frame_sync_ch0_oe_n,
  input wire logic frame_sync_ch1_out,
  input wire logic frame_sync_ch1_oe_n,
  input wire logic txd_oe_n,
  input wire logic serial_port_irq_n
);
  import dcsp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  chk_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_err: assert property (psel && !penable && paddr > OFS_STATUS |=> pslverr)
    else $error("no error on unmapped address");
  chk_mapped_ok: assert property (psel && !penable && paddr == OFS_CTRL |=> !pslverr)
    else $error("error on control access");
  chk_irq_pulse: assert property (!serial_port_irq_n |=> serial_port_irq_n)
    else $error("irq pulse longer than one cycle");
  chk_off_quiet: assert property (txd_oe_n |-> sclk_oe_n && frame_sync_ch0_oe_n)
    else $error("clock or sync driven while off");
  chk_off_sync1: assert property (txd_oe_n |-> frame_sync_ch1_oe_n)
    else $error("sync 1 driven while off");
  chk_sync0_driven: assert property ($rose(frame_sync_ch0_out) |-> !frame_sync_ch0_oe_n)
    else $error("sync 0 rose undriven");
  chk_sync1_driven: assert property ($rose(frame_sync_ch1_out) |-> !frame_sync_ch1_oe_n)
    else $error("sync 1 rose undriven");

  cov_irq: cover property ($fell(serial_port_irq_n));
  cov_err: cover property (psel && penable && pslverr);
  cov_sync1: cover property ($rose(frame_sync_ch1_out));
endmodule

// [test/dcsp_codec_model.sv]
/*
  Far-side codec: sends a left-aligned pattern MSB first, records txd,
  and can make clock and sync itself. Assumes the bench resolves wires.
*/
`timescale 1ns/10ps
module dcsp_codec_model (
  input wire logic sclk,
  input wire logic fs,
  input wire logic txd,
  input wire logic [63:0] tx_pat,
  input wire logic go,
  input wire logic [6:0] len,
  output logic rxd,
  output logic sclk_drv,
  output logic fs_drv,
  output logic [63:0] rx_sh
);
  logic [63:0] sh = '0;
  logic first = 1'b1;
  logic fs_q = 1'b0;
  initial begin
    sclk_drv = 1'b0;
    fs_drv = 1'b0;
    rx_sh = '0;
  end
  // Own clock, sync
  // Clock stands still outside frames
  always @(posedge go) begin
    // Odd offset keeps every pin change off the mclk edge
    #21 fs_drv = 1'b1;
    repeat (len) begin
      #20 sclk_drv = 1'b1;
      #20 sclk_drv = 1'b0;
    end
    #20 fs_drv = 1'b0;
  end
  always @(posedge fs) begin
    sh = tx_pat;
    first = 1'b1;
  end
  // Hold the MSB until the first falling edge
  always @(posedge sclk) begin
    if (fs && !first)
      sh = sh << 1;
    first = 1'b0;
    fs_q = fs;
  end
  always @(negedge sclk) begin
    if (fs_q)
      rx_sh = {rx_sh[62:0], txd};
  end
  // Released line shows no stale bit
  assign rxd = fs ? sh[63] : ~sh[63];
endmodule

// [test/tb_top.sv]
/*
  Bench: APB tasks and frame scenarios against the codec model.
  Assumes package, design, checker and model compiled before.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  import dcsp_pkg::*;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, sclk_out, sclk_oe_n, txd, txd_oe_n, rxd, irq;
  logic frame_sync_ch0_out, frame_sync_ch0_oe_n, frame_sync_ch1_out;
  logic frame_sync_ch1_oe_n, serial_port_irq_n, m_sclk, m_fs, sclk_q = 0;
  logic [63:0] m_tx = 0, m_rx, got;
  logic [6:0] m_len = 0;
  int n_fail = 0, n_tests = 0, per = 0, cnt = 0, nfs = 0, nf = 0, sl = 0;
  wire sclk_w = sclk_oe_n ? m_sclk : sclk_out;
  wire fs0_w = frame_sync_ch0_oe_n ? m_fs : frame_sync_ch0_out;
  // Pulled down: the far side never drives sync 1
  wire fs1_w = frame_sync_ch1_oe_n ? 1'b0 : frame_sync_ch1_out;
  wire fs_any = fs0_w | fs1_w;

  dcsp_serial_port dcsp_serial_port_i (.mclk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .sclk_in(sclk_w), .sclk_out,
    .sclk_oe_n, .frame_sync_ch0_in(fs0_w), .frame_sync_ch0_out,
    .frame_sync_ch0_oe_n, .frame_sync_ch1_in(fs1_w), .frame_sync_ch1_out,
    .frame_sync_ch1_oe_n, .txd, .txd_oe_n, .rxd, .irq, .serial_port_irq_n);
  dcsp_codec_model dcsp_codec_model_i (.sclk(sclk_w), .fs(fs_any), .txd,
    .tx_pat(m_tx), .go, .len(m_len), .rxd, .sclk_drv(m_sclk), .fs_drv(m_fs),
    .rx_sh(m_rx));

  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cnt++;
    if (sclk_out && !sclk_q) begin
      per = cnt;
      cnt = 0;
    end
    sclk_q = sclk_out;
  end
  always @(posedge sclk_w) if (fs_any) nfs++;
  always @(posedge fs_any) nfs = 0;
  always @(negedge fs_any) nf = nfs;

  task automatic conclude();
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    @(negedge mclk);
    `CHK("irq line", e, irq)
  endtask

  // ld: four words written; pat: model's bits; eg/er: expected sent/read
  task automatic scen(input logic [15:0] ctl, wcc, input logic [63:0] ld, pat,
                      eg, er, input logic [3:0] rw, input int len, ch);
    logic [63:0] mk;
    mk = (len == 64) ? '1 : (64'h1 << len) - 64'h1;
    m_tx = pat;
    m_len = len[6:0];
    for (int i = 0; i < 4; i++) apb(1'b1, DATA_OFS[i], {16'h0, ld[63-16*i -: 16]});
    apb(1'b1, OFS_WCC, {16'h0, wcc});
    apb(1'b1, OFS_CTRL, {16'h0, ctl});
    if (!wcc[4])
      go <= 1'b1;
    do @(posedge mclk); while (serial_port_irq_n !== 1'b0);
    // Taken now: the next internal frame starts before the port is off
    got = m_rx;
    sl = nf;
    go <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_WCC, {16'h0, WCC_RST});
    `CHK("sent bits", eg & mk, got & mk)
    for (int i = 0; i < 4; i++) begin
      if (rw[3-i]) begin
        apb(1'b0, DATA_OFS[i], 32'h0);
        `CHK("received word", {16'h0, er[63-16*i -: 16]}, rd)
      end
    end
    if (wcc[4])
      `CHK("sclk period", 2 * int'(wcc[3:0]), per)
    if (ctl[2])
      `CHK("sync length", len, sl)
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK("irq status", 32'h1 << ch, rd)
    irq_is(1'b1);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    irq_is(1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'h3);
    irq_is(1'b0);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    `CHK("port idle", 1'b1, txd_oe_n & sclk_oe_n)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("control reset", {16'h0, CTRL_RST}, rd)
    apb(1'b0, OFS_WCC, 32'h0);
    `CHK("clock control reset", {16'h0, WCC_RST}, rd)
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("engine idle", {29'h0, ST_IDLE}, rd)
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    scen(16'h000C, 16'h0011, 64'h0000_00A5_0000_0000, {8'h3C, 56'h0}, 64'hA5,
         64'h003C_0000_0000_0000, 4'b1000, 8, 0);
    scen(16'h0006, 16'h0033, 64'h0000_0000_0000_BEEF, 64'h1234_0000_0000_0000,
         64'hBEEF, 64'h0000_0000_1234_0000, 4'b0010, 16, 1);
    scen(16'h000D, 16'h0011, 64'h0000_1000_0000_0000, {8'h81, 56'h0}, 64'hAF,
         64'h0081_0000_0000_0000, 4'b1000, 8, 0);
    scen(16'h000F, 16'h0012, 64'h1122_3344_5566_7788, 64'hA1B2_C3D4_E5F6_0718,
         64'h1122_3344_5566_7788, 64'hA1B2_C3D4_E5F6_0718, 4'b1111, 64, 0);
    scen(16'h0008, 16'h0001, 64'h0000_005A_0000_0000, {8'hC3, 56'h0}, 64'h5A,
         64'h00C3_0000_0000_0000, 4'b1000, 8, 0);
    conclude();
  end

  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule

bind dcsp_serial_port dcsp_chk dcsp_chk_i (.mclk, .reset, .paddr, .psel, .penable,
  .pready, .pslverr, .sclk_oe_n, .frame_sync_ch0_out, .frame_sync_ch0_oe_n,
  .frame_sync_ch1_out, .frame_sync_ch1_oe_n, .txd_oe_n, .serial_port_irq_n);
